// ### shared/sst_pkg.sv
// Package of constants, types and register map for the safe-state and self-test controller
package sst_pkg;

  // ******************************************************************
  // Register map (byte addresses)
  // ******************************************************************
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  localparam logic [11:0] ADDR_OUT_EN = 12'h014;

  // ******************************************************************
  // Field positions and reset values
  // ******************************************************************
  localparam int ERR_BAND_HI = 12;
  localparam int ERR_BAND_LO = 11;
  localparam int TANGLE_HI = 7;
  localparam int TANGLE_LO = 6;
  localparam int TMODE_HI = 5;
  localparam int TMODE_LO = 4;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [3:0] OUT_EN_RESET = 4'hF;
  localparam int CTRL_START_BIT = 0;

  // Number of fault inputs and their positions
  localparam int NUM_FAULTS = 12;
  localparam int F_WIRE = 0;
  localparam int F_UV = 1;
  localparam int F_CFG = 2;
  localparam int F_EE = 3;
  localparam int F_OT = 4;
  localparam int F_MEM = 5;
  localparam int F_OV = 6;
  localparam int F_HALL = 7;
  localparam int F_BG = 8;
  localparam int F_CLK = 9;
  localparam int F_SPIN = 10;
  localparam int F_ZERO = 11;
  localparam int F_XBAR = NUM_FAULTS;
  localparam int NUM_IN = NUM_FAULTS + 1;
  // Faults fixed to High-Z
  localparam logic [NUM_IN-1:0] HIZ_ONLY_MASK = 13'h003F;
  // Faults with selectable safe state
  localparam logic [NUM_IN-1:0] SELECT_MASK = 13'h1FC0;

  // Interrupt bit positions
  localparam int IRQ_HIZ = 0;
  localparam int IRQ_BAND = 1;
  localparam int IRQ_TEST_DONE = 2;
  localparam int NUM_IRQ = 3;

  // ******************************************************************
  // Self-test timing
  // ******************************************************************
  localparam int STEP_COUNT = 16;
  localparam int STEP_TIME_US = 1;
  localparam int CLK_MHZ = 25;
  localparam int STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
  localparam logic [4:0] STEP_LAST = 5'(STEP_COUNT - 1);
  localparam logic [7:0] STEP_CYC_LAST = 8'(STEP_CYCLES - 1);

  // Error-band codes in config bits 12:11
  localparam logic [1:0] EB_HIZ = 2'h0;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [1:0] {
    DRV_NORMAL,
    DRV_HIZ,
    DRV_ANGLE,
    DRV_BAND
  } sst_drive_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HIZ,
    ST_ANGLE,
    ST_BAND
  } sst_state_type;

  typedef struct packed {
    sst_drive_type mode;
    logic [1:0] band_sel;
    logic [1:0] angle_sel;
    logic [1:0] test_mode;
  } sst_out_ctrl_type;

endpackage : sst_pkg

// ### logic/sst_ctrl.sv
// Safe-state controller and field-free self-test sequencer with APB registers
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module sst_ctrl
  import sst_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IN-1:0] fault_in,
  input wire logic prog_mode,
  output sst_out_ctrl_type out_ctrl,
  output logic [3:0] output_drv_en,
  output logic output_c_prog_sel,
  output logic irq
);

  // ******************************************************************
  // Fault input synchronisers
  // ******************************************************************
  logic [NUM_IN-1:0] fault_meta_q;
  logic [NUM_IN-1:0] fault_sync_q;
  logic prog_meta_q;
  logic prog_sync_q;

  // Two flops on every asynchronous monitor line
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fault_meta_q <= '0;
      fault_sync_q <= '0;
      prog_meta_q <= 1'b0;
      prog_sync_q <= 1'b0;
    end else begin
      fault_meta_q <= fault_in;
      fault_sync_q <= fault_meta_q;
      prog_meta_q <= prog_mode;
      prog_sync_q <= prog_meta_q;
    end
  end

  // ******************************************************************
  // Fault classification
  // ******************************************************************
  // Any fault of one class present
  function automatic logic any_set(input logic [NUM_IN-1:0] v, input logic [NUM_IN-1:0] m);
    any_set = |(v & m);
  endfunction : any_set

  // Fault class levels
  logic hiz_fault;
  logic sel_fault;
  // Monitors sampled every cycle, start-up and normal run alike
  assign hiz_fault = any_set(fault_sync_q, HIZ_ONLY_MASK);
  assign sel_fault = any_set(fault_sync_q, SELECT_MASK);

  // ******************************************************************
  // Registers
  // ******************************************************************
  // Software visible configuration
  logic [15:0] config_q;
  logic [15:0] config_d;
  logic [3:0] out_en_q;
  logic [3:0] out_en_d;
  // Sticky event flags and their mask
  logic [NUM_IRQ-1:0] irq_stat_q;
  logic [NUM_IRQ-1:0] irq_stat_d;
  logic [NUM_IRQ-1:0] irq_mask_q;
  logic [NUM_IRQ-1:0] irq_mask_d;
  // Bus answer: ready and error held for one cycle, read data held until the next read
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  // Strobes between bus decode and sequencer
  logic start_req;
  logic test_done;
  // Previous fault levels for edge detection
  logic hiz_prev_q;
  logic band_prev_q;
  // Sequencer state, step and cycle counters
  sst_state_type state_q;
  sst_state_type state_d;
  logic [4:0] step_q;
  logic [4:0] step_d;
  logic [7:0] cyc_q;
  logic [7:0] cyc_d;
  logic powerup_q;
  logic powerup_d;

  // Access cycle of a transfer, one per transfer
  logic access;
  logic wr;
  assign access = psel && penable && !pready_q;
  assign wr = access && pwrite;

  // Mapped register offsets
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == ADDR_CONFIG) || (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
              (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK) || (a == ADDR_OUT_EN);
  endfunction : addr_ok

  // Bus decode, register writes and sticky interrupt flags
  always_comb begin
    config_d = config_q;
    out_en_d = out_en_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    prdata_d = prdata_q;
    pready_d = access;
    pslverr_d = access && !addr_ok(paddr);
    start_req = 1'b0;
    if (wr) begin
      case (paddr)
        ADDR_CONFIG: config_d = pwdata[15:0];
        ADDR_CTRL: start_req = pwdata[CTRL_START_BIT];
        ADDR_IRQ_STAT: irq_stat_d = irq_stat_q & ~pwdata[NUM_IRQ-1:0];
        ADDR_IRQ_MASK: irq_mask_d = pwdata[NUM_IRQ-1:0];
        ADDR_OUT_EN: out_en_d = pwdata[3:0];
        default: ;
      endcase
    end
    if (access && !pwrite) begin
      case (paddr)
        ADDR_CONFIG: prdata_d = {16'h0000, config_q};
        ADDR_STATUS: prdata_d = {14'h0000, 2'(state_q), 3'h0, fault_sync_q};
        ADDR_IRQ_STAT: prdata_d = {29'h00000000, irq_stat_q};
        ADDR_IRQ_MASK: prdata_d = {29'h00000000, irq_mask_q};
        ADDR_OUT_EN: prdata_d = {28'h0000000, out_en_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (hiz_fault && !hiz_prev_q) irq_stat_d[IRQ_HIZ] = 1'b1;
    if (sel_fault && !band_prev_q) irq_stat_d[IRQ_BAND] = 1'b1;
    if (test_done) irq_stat_d[IRQ_TEST_DONE] = 1'b1;
  end

  // Register stage of bus and flag state
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      config_q <= CONFIG_RESET;
      out_en_q <= OUT_EN_RESET;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      hiz_prev_q <= 1'b0;
      band_prev_q <= 1'b0;
    end else begin
      config_q <= config_d;
      out_en_q <= out_en_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      hiz_prev_q <= hiz_fault;
      band_prev_q <= sel_fault;
    end
  end

  // ******************************************************************
  // Self-test sequencer
  // ******************************************************************
  // End of one step and of one sixteen-step phase
  logic step_end;
  logic phase_end;
  assign step_end = (cyc_q == STEP_CYC_LAST);
  assign phase_end = step_end && (step_q == STEP_LAST);

  // Test offered once after power-up, started by software
  always_comb begin
    state_d = state_q;
    step_d = step_q;
    cyc_d = cyc_q;
    powerup_d = powerup_q;
    test_done = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start_req && powerup_q) begin
          state_d = ST_HIZ;
          powerup_d = 1'b0;
          step_d = 5'h00;
          cyc_d = 8'h00;
        end
      end
      ST_HIZ, ST_ANGLE, ST_BAND: begin
        cyc_d = cyc_q + 8'h01;
        if (step_end) begin
          cyc_d = 8'h00;
          step_d = step_q + 5'h01;
          if (phase_end) begin
            step_d = 5'h00;
            case (state_q)
              ST_HIZ: state_d = ST_ANGLE;
              ST_ANGLE: state_d = ST_BAND;
              default: begin
                state_d = ST_IDLE;
                test_done = 1'b1;
              end
            endcase
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Register stage of the sequencer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      step_q <= 5'h00;
      cyc_q <= 8'h00;
      powerup_q <= 1'b1;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      cyc_q <= cyc_d;
      powerup_q <= powerup_d;
    end
  end

  // ******************************************************************
  // Output drive selection
  // ******************************************************************
  // Registered output drive and its next value
  sst_out_ctrl_type out_ctrl_q;
  sst_out_ctrl_type out_ctrl_d;
  logic [3:0] drv_en_q;
  logic [3:0] drv_en_d;
  // Programming pin select and interrupt line
  logic prog_sel_q;
  logic prog_sel_d;
  logic irq_q;
  logic irq_d;

  // Safe state of a selectable fault from the error-band field
  function automatic sst_drive_type band_mode(input logic [1:0] sel);
    band_mode = (sel == EB_HIZ) ? DRV_HIZ : DRV_BAND;
  endfunction : band_mode

  // Drive pattern of each self-test phase
  function automatic sst_drive_type phase_mode(input sst_state_type s);
    case (s)
      ST_HIZ: phase_mode = DRV_HIZ;
      ST_ANGLE: phase_mode = DRV_ANGLE;
      ST_BAND: phase_mode = DRV_BAND;
      default: phase_mode = DRV_NORMAL;
    endcase
  endfunction : phase_mode

  // High-Z faults outrank everything, then selectable faults, then test
  always_comb begin
    out_ctrl_d.band_sel = config_q[ERR_BAND_HI:ERR_BAND_LO];
    out_ctrl_d.angle_sel = config_q[TANGLE_HI:TANGLE_LO];
    out_ctrl_d.test_mode = config_q[TMODE_HI:TMODE_LO];
    prog_sel_d = prog_sync_q;
    irq_d = |(irq_stat_d & irq_mask_q);
    if (hiz_fault) begin
      out_ctrl_d.mode = DRV_HIZ;
    end else if (sel_fault) begin
      out_ctrl_d.mode = band_mode(config_q[ERR_BAND_HI:ERR_BAND_LO]);
    end else begin
      out_ctrl_d.mode = phase_mode(state_q);
    end
  end

  // Each driver on only while enabled and not in High-Z
  for (genvar g = 0; g < 4; g++) begin : g_drv
    assign drv_en_d[g] = out_en_q[g] && (out_ctrl_d.mode != DRV_HIZ);
  end

  // Register stage of the output drive
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      out_ctrl_q <= '{mode: DRV_HIZ, band_sel: 2'h0, angle_sel: 2'h0, test_mode: 2'h0};
      drv_en_q <= 4'h0;
      prog_sel_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      out_ctrl_q <= out_ctrl_d;
      drv_en_q <= drv_en_d;
      prog_sel_q <= prog_sel_d;
      irq_q <= irq_d;
    end
  end

  // Output ports straight from flops
  assign out_ctrl = out_ctrl_q;
  assign output_drv_en = drv_en_q;
  assign output_c_prog_sel = prog_sel_q;
  assign irq = irq_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : sst_ctrl

// ### dv/sst_ctrl_assertions.sv
// Checker of safe-state and self-test behaviour at the controller ports
`timescale 1ns/1ps
module sst_ctrl_assertions
  import sst_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [NUM_IN-1:0] fault_in,
  input wire logic prog_mode,
  input wire sst_out_ctrl_type out_ctrl,
  input wire logic [3:0] output_drv_en,
  input wire logic output_c_prog_sel
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ************
  // Helper logic
  // ************
  logic [9:0] run_d;
  logic [9:0] run_q;
  logic hiz_f;
  logic sel_f;
  // Fault classes seen at the inputs
  assign hiz_f = |(fault_in & HIZ_ONLY_MASK);
  assign sel_f = |(fault_in & SELECT_MASK);
  // Length of the current angle run
  always_comb begin
    run_d = (out_ctrl.mode == DRV_ANGLE) ? run_q + 10'h001 : 10'h000;
  end
  always_ff @(posedge mclk) begin
    run_q <= reset_n ? run_d : 10'h000;
  end
  sequence s_hiz_held;
    hiz_f [*5];
  endsequence
  sequence s_sel_held;
    (sel_f && !hiz_f) [*5];
  endsequence
  sequence s_angle_end;
    out_ctrl.mode == DRV_ANGLE ##1 out_ctrl.mode == DRV_BAND;
  endsequence
  // ************
  // Assertions
  // ************
  a_hiz_drv_off: assert property (
    out_ctrl.mode == DRV_HIZ |-> output_drv_en == 4'h0) else $error("drivers on in high-z");
  a_hiz_fault_wins: assert property (
    s_hiz_held |-> out_ctrl.mode == DRV_HIZ) else $error("fixed fault not high-z");
  a_sel_fault_state: assert property (
    s_sel_held |-> out_ctrl.mode == ((out_ctrl.band_sel == EB_HIZ) ? DRV_HIZ : DRV_BAND))
    else $error("selectable fault state wrong");
  a_angle_entry: assert property (
    out_ctrl.mode == DRV_ANGLE && $past(out_ctrl.mode) != DRV_ANGLE
    |-> $past(out_ctrl.mode) == DRV_HIZ) else $error("angle not after high-z");
  a_angle_len: assert property (
    out_ctrl.mode != DRV_ANGLE && run_q != 10'h000 |-> run_q == 10'h190)
    else $error("angle phase length wrong");
  a_band_then_normal: assert property (
    s_angle_end |-> ##[399:399] out_ctrl.mode == DRV_BAND ##1 out_ctrl.mode == DRV_NORMAL)
    else $error("band phase or return wrong");
  a_prog_on: assert property (
    prog_mode [*5] |-> output_c_prog_sel) else $error("programming pin not selected");
  a_prog_off: assert property (
    !prog_mode [*5] |-> !output_c_prog_sel) else $error("programming pin stuck");
endmodule : sst_ctrl_assertions

bind sst_ctrl sst_ctrl_assertions sst_ctrl_assertions_i (.mclk, .reset_n, .fault_in,
  .prog_mode, .out_ctrl, .output_drv_en, .output_c_prog_sel);

// ### dv/sst_ecu_model.sv
// Model of the outside controller judging the output drive
`timescale 1ns/1ps
module sst_ecu_model
  import sst_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire sst_out_ctrl_type out_ctrl,
  input wire logic [3:0] output_drv_en,
  output logic test_seen,
  output logic pair_bad
);
  logic [9:0] len_q;
  logic [9:0] ang_q;
  sst_drive_type last_q;
  // Run lengths per drive mode and own pattern verdict
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      len_q <= 10'h000;
      ang_q <= 10'h000;
      last_q <= DRV_HIZ;
      test_seen <= 1'b0;
      pair_bad <= 1'b0;
    end else begin
      last_q <= out_ctrl.mode;
      len_q <= (out_ctrl.mode == last_q) ? len_q + 10'h001 : 10'h001;
      if (last_q == DRV_ANGLE && out_ctrl.mode == DRV_BAND) begin
        ang_q <= len_q;
      end
      if (last_q == DRV_BAND && out_ctrl.mode == DRV_NORMAL) begin
        test_seen <= (ang_q == 10'h190) && (len_q == 10'h190);
      end
      pair_bad <= (out_ctrl.mode == DRV_NORMAL) && (output_drv_en[0] != output_drv_en[1]);
    end
  end
endmodule : sst_ecu_model

// ### dv/test_safe_state_and_selftest_control.sv
// Self-checking bench of the safe-state and self-test controller
`timescale 1ns/1ps
module test_safe_state_and_selftest_control;
  import sst_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic prog_mode = 1'b0;
  logic look = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [NUM_IN-1:0] fault_in = 13'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, output_c_prog_sel, test_seen, pair_bad;
  logic [3:0] output_drv_en;
  sst_out_ctrl_type out_ctrl;
  logic [32:0] exp_q[$];
  int fails = 0;
  int tests_run = 0;
  logic [15:0] exp_cfg = CONFIG_RESET;
  logic [3:0] exp_en = OUT_EN_RESET;

  always #20 mclk = ~mclk;

  sst_ctrl sst_ctrl_i (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fault_in, .prog_mode, .out_ctrl, .output_drv_en,
    .output_c_prog_sel, .irq);
  sst_ecu_model sst_ecu_model_i (.mclk, .reset_n, .out_ctrl, .output_drv_en, .test_seen,
    .pair_bad);

  // Compare each read or look with the oldest note
  always @(posedge mclk) begin : mon
    logic [32:0] act;
    logic [32:0] e;
    if ((pready === 1'b1 && pwrite === 1'b0) || look) begin
      act = look ? {17'h0, output_drv_en, out_ctrl.band_sel, out_ctrl.angle_sel,
                    out_ctrl.test_mode, pair_bad, test_seen, output_c_prog_sel, irq,
                    out_ctrl.mode} : {pslverr, prdata};
      e = exp_q.pop_front();
      tests_run++;
      if (act !== e) begin
        fails++;
        $display("unexpected at %0t: got %h expected %h", $time, act, e);
      end
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic peek(input logic [5:0] e);
    logic [3:0] en;
    // Drivers off in High-Z, else as last enabled
    en = (e[1:0] == DRV_HIZ) ? 4'h0 : exp_en;
    exp_q.push_back({17'h0, en, exp_cfg[ERR_BAND_HI:ERR_BAND_LO], exp_cfg[TANGLE_HI:TANGLE_LO],
                     exp_cfg[TMODE_HI:TMODE_LO], e});
    look <= 1'b1;
    @(posedge mclk);
    look <= 1'b0;
  endtask : peek

  task automatic end_of_test();
    // A note never matched is a miss
    if (exp_q.size() != 0) fails++;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin : main
    logic [31:0] cfg;
    logic [1:0] b;
    logic [NUM_IN-1:0] f;
    sst_drive_type m;
    logic [3:0] en;
    void'($urandom(32'h04472EC1));
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values and an unmapped place
    apb(1'b0, ADDR_CONFIG, 32'h0, 33'h0);
    apb(1'b0, ADDR_OUT_EN, 32'h0, {29'h0, OUT_EN_RESET});
    apb(1'b0, ADDR_IRQ_MASK, 32'h0, 33'h0);
    apb(1'b0, 12'h020, 32'h0, 33'h100000000);
    peek({4'h0, DRV_NORMAL});
    $display("reset test done");
    // Every fault alone, odd-numbered fixed ones beside the selectable crossbar fault instead
    apb(1'b1, ADDR_IRQ_MASK, 32'h00000003, 33'h0);
    for (int i = 0; i < NUM_IN; i++) begin
      b = (i % 2 == 1) ? 2'($urandom_range(3, 1)) : EB_HIZ;
      exp_cfg = {3'h0, b, 11'h0};
      apb(1'b1, ADDR_CONFIG, {19'h0, b, 11'h0}, 33'h0);
      f = 13'h0001 << i;
      if (i <= F_MEM && i % 2 == 1) f = f | 13'h1000;
      m = (i <= F_MEM || b == EB_HIZ) ? DRV_HIZ : DRV_BAND;
      fault_in <= f;
      repeat (6) @(posedge mclk);
      peek({3'h0, 1'b1, m});
      apb(1'b0, ADDR_STATUS, 32'h0, {20'h0, f});
      fault_in <= 13'h0000;
      repeat (6) @(posedge mclk);
      apb(1'b1, ADDR_IRQ_STAT, 32'h00000007, 33'h0);
      repeat (2) @(posedge mclk);
      peek({4'h0, DRV_NORMAL});
    end
    // Masked event keeps the line low until unmasked
    apb(1'b1, ADDR_IRQ_MASK, 32'h0, 33'h0);
    fault_in <= 13'h0010;
    repeat (6) @(posedge mclk);
    peek({4'h0, DRV_HIZ});
    apb(1'b1, ADDR_IRQ_MASK, 32'h00000001, 33'h0);
    repeat (2) @(posedge mclk);
    peek({3'h0, 1'b1, DRV_HIZ});
    fault_in <= 13'h0000;
    apb(1'b1, ADDR_IRQ_STAT, 32'h00000007, 33'h0);
    $display("fault test done");
    // Field-free self-test, then a second start that is ignored
    cfg = 32'($urandom_range(255, 0)) & 32'h000000F0;
    exp_cfg = cfg[15:0];
    apb(1'b1, ADDR_CONFIG, cfg, 33'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h00000004, 33'h0);
    apb(1'b1, ADDR_CTRL, 32'h00000001, 33'h0);
    repeat (200) @(posedge mclk);
    peek({4'h0, DRV_HIZ});
    repeat (399) @(posedge mclk);
    peek({4'h0, DRV_ANGLE});
    repeat (399) @(posedge mclk);
    peek({4'h0, DRV_BAND});
    repeat (399) @(posedge mclk);
    peek({3'h2, 1'b1, DRV_NORMAL});
    apb(1'b1, ADDR_IRQ_STAT, 32'h00000004, 33'h0);
    apb(1'b1, ADDR_CTRL, 32'h00000001, 33'h0);
    repeat (200) @(posedge mclk);
    peek({3'h2, 1'b0, DRV_NORMAL});
    $display("self-test done");
    // Programming function stays on output C
    prog_mode <= 1'b1;
    repeat (5) @(posedge mclk);
    peek({2'h1, 1'b1, 1'b0, DRV_NORMAL});
    prog_mode <= 1'b0;
    repeat (5) @(posedge mclk);
    peek({3'h2, 1'b0, DRV_NORMAL});
    $display("programming test done");
    // Unused drivers switched off, sine pair kept together
    en = {2'($urandom_range(3, 0)), 2'h3};
    exp_en = en;
    apb(1'b1, ADDR_OUT_EN, {28'h0, en}, 33'h0);
    peek({3'h2, 1'b0, DRV_NORMAL});
    apb(1'b0, ADDR_OUT_EN, 32'h0, {29'h0, en});
    $display("driver test done");
    repeat (2) @(posedge mclk);
    end_of_test();
  end

  // Cut a hang short
  initial begin : watchdog
    #400000;
    fails++;
    end_of_test();
  end
endmodule : test_safe_state_and_selftest_control
